// *** cas_pkg.sv ***
// Purpose: constants and types shared by the charger monitoring converter sequencer
// Assumes: 16-bit register port, eight monitored channels
// Notes:   offsets index 16-bit registers on the plain register port
package cas_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 16;
    localparam int RES_W    = 16;
    localparam int NCH      = 8;
    localparam int CH_W     = 3;
    localparam int IDX_W    = 4;
    localparam int SPEED_W  = 2;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CHDIS   = 8'h01;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h02;
    localparam logic [ADDR_W-1:0] OFF_FLAG    = 8'h03;
    localparam logic [ADDR_W-1:0] OFF_RESULT0 = 8'h10;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_EN       = 0;
    localparam int CTRL_ONESHOT  = 1;
    localparam int CTRL_AVG      = 2;
    localparam int CTRL_SEED     = 3;
    localparam int CTRL_SPEED_LO = 4;
    localparam int CTRL_BATSENSE = 6;
    localparam int CTRL_DONEMASK = 7;

    // status and flag fields
    localparam int STS_DONE   = 0;
    localparam int STS_BUSY   = 1;
    localparam int STS_SUPPLY = 2;
    localparam int STS_HOLD   = 3;
    localparam int FLG_DONE   = 0;

    // ------------------------------------------------------------
    // channel numbers and reset values
    // ------------------------------------------------------------
    localparam logic [CH_W-1:0] CH_CHG_CURRENT = 3'h3;
    localparam logic [CH_W-1:0] CH_THERMISTOR  = 3'h6;

    localparam logic [NCH-1:0]     RST_CHDIS  = 8'h00;
    localparam logic [SPEED_W-1:0] RST_SPEED  = 2'h0;
    localparam logic [RES_W-1:0]   RST_RESULT = 16'h0000;

    typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_START, ST_CONV} cas_state_t;

endpackage

// *** cas_adc_sequencer.sv ***
// Purpose: sequencer for the charger's 16-bit monitoring converter
// Assumes: converter answers each start with one convDone pulse; inputs synchronous to clk
// Notes:   results held in a local array, read over the plain register port
`timescale 1ns/100ps

// Notes on behaviour
// - each channel result is stored with 16-bit resolution
// - conversion runs only while enable is set; clearing it powers converter down
// - rate bit picks continuous or single pass; single pass clears enable
// - averaging off by default; seed bit picks stored value or fresh sample
// - converter runs only with ac sense, vbus or battery supply valid
// - enable set before supply is valid waits, then starts converting
// - high impedance input mode does not block conversion
// - battery only: 3.2V needed with thermistor channel, else 2.9V
// - speed change mid conversion reconverts that channel at new speed
// - all channels enabled at reset; disabled channel keeps last result
// - channel disabled mid cycle finishes, then is skipped
// - with all channels disabled stay ready; start once one is enabled
// - single pass done sets status, flag and alert pulse unless masked
// - continuous mode keeps done status and done flag at zero
// - faults never stop conversion; software clears enable to stop
// - adapter insertion halts conversion until detection completes
// - bias regulator not forced by enable, forced by thermistor channel
// - charge current channel reads zero in trickle, supplement or charge disable with averaging off
// - battery only: current sense amp on only when software enables it
// - stop cleanly by single pass rate or by disabling all channels
module cas_adc_sequencer
    import cas_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // register port
    input  wire logic [ADDR_W-1:0]    addr,
    input  wire logic [DATA_W-1:0]    wrData,
    input  wire logic                 wrEn,
    input  wire logic                 rdEn,
    output logic      [DATA_W-1:0]    rdData_r,
    // supply qualification and charger state
    input  wire logic                 acSenseOk,
    input  wire logic                 vbusOk,
    input  wire logic                 battAbove29,
    input  wire logic                 battAbove32,
    input  wire logic                 batteryOnly,
    input  wire logic                 adapterInsert,
    input  wire logic                 detectionDone,
    input  wire logic                 trickleCharge,
    input  wire logic                 supplementMode,
    input  wire logic                 chargeDisabled,
    // converter
    output logic                      convStart_r,
    output logic      [CH_W-1:0]      convChannel_r,
    output logic      [SPEED_W-1:0]   convSpeed_r,
    output logic                      convPowerOn_r,
    input  wire logic                 convDone,
    input  wire logic [RES_W-1:0]     convData,
    // analog support and alert
    output logic                      biasRegulatorOn_r,
    output logic                      currentSenseAmpOn_r,
    output logic                      doneAlert_r
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic                ctrlEn_r;
    logic                rateOneShot_r;
    logic                avgEn_r;
    logic                avgSeedFresh_r;
    logic [SPEED_W-1:0]  speed_r;
    logic                battSenseOn_r;
    logic                doneMask_r;
    logic [NCH-1:0]      chanDis_r;
    logic                doneStat_r;
    logic                doneFlag_r;
    logic                hold_r;
    logic [NCH-1:0]      seeded_r;
    logic [RES_W-1:0]    resultMem [NCH];
    cas_state_t          state_r;
    cas_state_t          state_nxt;
    logic [IDX_W-1:0]    curCh_r;
    logic [IDX_W-1:0]    curCh_nxt;

    // ------------------------------------------------------------
    // channel search
    // ------------------------------------------------------------
    // lowest enabled channel at or above start, NCH when none
    function automatic logic [IDX_W-1:0] nextFrom(input logic [IDX_W-1:0] start, input logic [NCH-1:0] en);
        logic [IDX_W-1:0] r;
        r = IDX_W'(NCH);
        for (int i = NCH - 1; i >= 0; i--) begin
            if (en[i] && (i >= int'(start))) begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire                   wrCtrl      = wrEn && (addr == OFF_CTRL);
    wire                   wrChdis     = wrEn && (addr == OFF_CHDIS);
    wire                   rdFlag      = rdEn && (addr == OFF_FLAG);
    wire                   rdResult    = (addr[ADDR_W-1:CH_W] == OFF_RESULT0[ADDR_W-1:CH_W]);
    wire [NCH-1:0]         chEn        = ~chanDis_r;
    wire                   thermEn     = chEn[CH_THERMISTOR];
    wire                   anyEn       = |chEn;
    wire                   battOk      = thermEn ? battAbove32 : battAbove29;
    wire                   supplyOk    = acSenseOk || vbusOk || battOk;
    // no fault input and no input-mode term gate the run condition
    wire                   runOk       = ctrlEn_r && supplyOk && !hold_r && anyEn;
    wire                   abortConv   = !ctrlEn_r || !supplyOk || hold_r || adapterInsert;
    wire                   speedChg    = (speed_r != convSpeed_r);
    wire                   resultTake  = (state_r == ST_CONV) && convDone && !abortConv && !speedChg;
    wire [IDX_W-1:0]       resumeCh    = nextFrom(curCh_r, chEn);
    wire [IDX_W-1:0]       firstCh     = nextFrom(IDX_W'(0), chEn);
    wire [IDX_W-1:0]       afterCh     = nextFrom(curCh_r + IDX_W'(1), chEn);
    wire                   cycleEnd    = resultTake && (afterCh == IDX_W'(NCH));
    wire                   finishShot  = cycleEnd && rateOneShot_r;
    wire                   chgZero     = trickleCharge || supplementMode || chargeDisabled;
    wire [RES_W-1:0]       rawVal      = ((convChannel_r == CH_CHG_CURRENT) && chgZero) ? RST_RESULT : convData;
    wire                   enRise      = wrCtrl && wrData[CTRL_EN] && !ctrlEn_r;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    wire ctrlEn_nxt = wrCtrl ? wrData[CTRL_EN] : (finishShot ? 1'b0 : ctrlEn_r);

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlEn_r       <= 1'b0;
            rateOneShot_r  <= 1'b0;
            avgEn_r        <= 1'b0;
            avgSeedFresh_r <= 1'b0;
            speed_r        <= RST_SPEED;
            battSenseOn_r  <= 1'b0;
            doneMask_r     <= 1'b0;
        end else begin
            ctrlEn_r <= ctrlEn_nxt;
            if (wrCtrl) begin
                rateOneShot_r  <= wrData[CTRL_ONESHOT];
                avgEn_r        <= wrData[CTRL_AVG];
                avgSeedFresh_r <= wrData[CTRL_SEED];
                speed_r        <= wrData[CTRL_SPEED_LO +: SPEED_W];
                battSenseOn_r  <= wrData[CTRL_BATSENSE];
                doneMask_r     <= wrData[CTRL_DONEMASK];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            chanDis_r <= RST_CHDIS;
        end else if (wrChdis) begin
            chanDis_r <= wrData[NCH-1:0];
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        curCh_nxt = curCh_r;
        case (state_r)
            ST_OFF: begin
                if (ctrlEn_r) begin
                    state_nxt = ST_WAIT;
                    curCh_nxt = IDX_W'(0);
                end
            end
            ST_WAIT: begin
                if (!ctrlEn_r) begin
                    state_nxt = ST_OFF;
                end else if (runOk) begin
                    state_nxt = ST_START;
                    curCh_nxt = (resumeCh != IDX_W'(NCH)) ? resumeCh : firstCh;
                end
            end
            ST_START: begin
                if (abortConv) begin
                    state_nxt = ctrlEn_r ? ST_WAIT : ST_OFF;
                end else begin
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                if (abortConv) begin
                    state_nxt = ctrlEn_r ? ST_WAIT : ST_OFF;
                end else if (speedChg) begin
                    state_nxt = ST_START;
                end else if (resultTake) begin
                    if (!cycleEnd) begin
                        state_nxt = ST_START;
                        curCh_nxt = afterCh;
                    end else if (rateOneShot_r) begin
                        state_nxt = ST_OFF;
                    end else begin
                        state_nxt = ST_WAIT;
                        curCh_nxt = IDX_W'(0);
                    end
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r       <= ST_OFF;
            curCh_r       <= '0;
            convStart_r   <= 1'b0;
            convChannel_r <= '0;
            convSpeed_r   <= RST_SPEED;
        end else begin
            state_r     <= state_nxt;
            curCh_r     <= curCh_nxt;
            convStart_r <= (state_r == ST_START) && !abortConv;
            if ((state_r == ST_START) && !abortConv) begin
                convChannel_r <= curCh_r[CH_W-1:0];
                convSpeed_r   <= speed_r;
            end
        end
    end

    // ------------------------------------------------------------
    // result storage with optional averaging
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NCH; g++) begin : gChan
            wire              take   = resultTake && (convChannel_r == CH_W'(g));
            wire [RES_W:0]    sum    = {1'b0, resultMem[g]} + {1'b0, rawVal};
            wire [RES_W-1:0]  avgVal = sum[RES_W:1];
            wire              fresh  = !avgEn_r || (!seeded_r[g] && avgSeedFresh_r);
            always_ff @(posedge clk) begin
                if (rst) begin
                    resultMem[g] <= RST_RESULT;
                    seeded_r[g]  <= 1'b0;
                end else begin
                    if (take) begin
                        resultMem[g] <= fresh ? rawVal : avgVal;
                    end
                    if (take) begin
                        seeded_r[g] <= 1'b1;
                    end else if (!avgEn_r || enRise) begin
                        seeded_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // done status, flag, alert and analog support
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            doneStat_r          <= 1'b0;
            doneFlag_r          <= 1'b0;
            doneAlert_r         <= 1'b0;
            hold_r              <= 1'b0;
            biasRegulatorOn_r   <= 1'b0;
            currentSenseAmpOn_r <= 1'b0;
            convPowerOn_r       <= 1'b0;
        end else begin
            doneStat_r  <= rateOneShot_r && (finishShot || (doneStat_r && !enRise));
            doneFlag_r  <= rateOneShot_r && (finishShot || (doneFlag_r && !rdFlag));
            doneAlert_r <= finishShot && !doneMask_r;
            hold_r      <= adapterInsert || (hold_r && !detectionDone);
            biasRegulatorOn_r   <= thermEn;
            currentSenseAmpOn_r <= !batteryOnly || battSenseOn_r;
            convPowerOn_r       <= ctrlEn_r;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire [DATA_W-1:0] ctrlView = {8'h00, doneMask_r, battSenseOn_r, speed_r, avgSeedFresh_r,
                                  avgEn_r, rateOneShot_r, ctrlEn_r};
    wire [DATA_W-1:0] statView = {12'h000, hold_r, supplyOk, (state_r != ST_OFF), doneStat_r};
    wire [DATA_W-1:0] rdMux    = (addr == OFF_CTRL)   ? ctrlView :
                                 (addr == OFF_CHDIS)  ? {8'h00, chanDis_r} :
                                 (addr == OFF_STATUS) ? statView :
                                 (addr == OFF_FLAG)   ? {15'h0000, doneFlag_r} :
                                 rdResult             ? resultMem[addr[CH_W-1:0]] :
                                 16'h0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_r <= '0;
        end else begin
            rdData_r <= rdEn ? rdMux : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_ONESHOT_END: assert property (finishShot && !wrCtrl |=> !ctrlEn_r && doneStat_r && doneFlag_r)
        else $error("single pass end did not clear enable and set done");
    AST_OFF_QUIET: assert property (!ctrlEn_r [*2] |-> !convPowerOn_r && !convStart_r)
        else $error("converter active while disabled");
    AST_SUPPLY_GATE: assert property (convStart_r |-> $past(supplyOk) && $past(ctrlEn_r))
        else $error("conversion started without a valid supply");
    AST_CONT_ZERO: assert property (!rateOneShot_r |=> !doneStat_r && !doneFlag_r)
        else $error("done bits set in continuous mode");
    AST_ALERT_MASK: assert property (doneAlert_r |-> $past(finishShot) && !$past(doneMask_r))
        else $error("alert pulse without unmasked single pass end");
    AST_BIAS_THERM: assert property (!chanDis_r[CH_THERMISTOR] |=> biasRegulatorOn_r)
        else $error("bias regulator off with thermistor channel enabled");
    AST_HOLD_NO_START: assert property (adapterInsert |=> !convStart_r ##1 !convStart_r)
        else $error("conversion started during adapter detection");
    AST_SPEED_REDO: assert property ((state_r == ST_CONV) && speedChg && !abortConv
                                     |=> (state_r == ST_START) && (curCh_r == $past(curCh_r))
                                     ##1 convStart_r && (convSpeed_r == $past(speed_r, 2)))
        else $error("speed change did not reconvert same channel");
    AST_ALL_DISABLED: assert property (!anyEn && (state_r != ST_CONV) && (state_r != ST_START)
                                       |=> !convStart_r)
        else $error("conversion started with all channels disabled");
    AST_CHG_ZERO: assert property (resultTake && (convChannel_r == CH_CHG_CURRENT) && chgZero && !avgEn_r
                                   |=> resultMem[CH_CHG_CURRENT] == 16'h0000)
        else $error("charge current channel not zero");
    AST_ORDER: assert property (resultTake && !cycleEnd |=> curCh_r > $past(curCh_r))
        else $error("channels not visited in ascending order");

endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the monitoring converter sequencer
// Assumes: bench answers every convStart_r with convDone four cycles later
// Notes:   converter data is 16'ha000 plus the channel number
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module tb_top
    import cas_pkg::*;
;
    logic clk = 0, rst = 1, wrEn = 0, rdEn = 0, convDone = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wrData = '0, rdData_r;
    logic [RES_W-1:0] convData = '0;
    logic acSenseOk = 0, vbusOk = 1, battAbove29 = 0, battAbove32 = 0, batteryOnly = 0, trickleCharge = 0;
    logic adapterInsert = 0, detectionDone = 0;
    logic convStart_r, convPowerOn_r, biasRegulatorOn_r, currentSenseAmpOn_r, doneAlert_r;
    logic [CH_W-1:0] convChannel_r, ch = '0;
    logic [SPEED_W-1:0] convSpeed_r;
    logic [1:0] dly = '0;
    logic [DATA_W-1:0] d;
    int fails = 0, total_checks = 0, starts = 0, alerts = 0, cyc = 0, s0;
    cas_adc_sequencer u_cas_adc_sequencer (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
        .rdEn(rdEn), .rdData_r(rdData_r), .acSenseOk(acSenseOk), .vbusOk(vbusOk), .battAbove29(battAbove29),
        .battAbove32(battAbove32), .batteryOnly(batteryOnly), .adapterInsert(adapterInsert),
        .detectionDone(detectionDone),
        .trickleCharge(trickleCharge), .supplementMode(1'b0), .chargeDisabled(1'b0),
        .convStart_r(convStart_r), .convChannel_r(convChannel_r), .convSpeed_r(convSpeed_r),
        .convPowerOn_r(convPowerOn_r), .convDone(convDone), .convData(convData),
        .biasRegulatorOn_r(biasRegulatorOn_r), .currentSenseAmpOn_r(currentSenseAmpOn_r),
        .doneAlert_r(doneAlert_r));
    always #2 clk = ~clk;
    // ------------------------------------------------------------
    // converter stand-in, event counters and watchdog
    // ------------------------------------------------------------
    always @(posedge clk) begin
        convDone <= 1'b0;
        cyc <= cyc + 1;
        if (convStart_r) begin
            dly <= 2'h3;
            ch  <= convChannel_r;
            starts <= starts + 1;
        end else if (dly != 2'h0) begin
            dly <= dly - 2'h1;
            if (dly == 2'h1) begin
                convDone <= 1'b1;
                convData <= 16'ha000 | {13'h0000, ch};
            end
        end
        if (doneAlert_r) alerts <= alerts + 1;
        if (cyc == 5000) begin
            fails++;
            final_report();
        end
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk) begin addr <= a; wrData <= v; wrEn <= 1'b1; end
        @(posedge clk) wrEn <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk) begin addr <= a; rdEn <= 1'b1; end
        @(posedge clk) rdEn <= 1'b0;
        // taken at the following edge, before the port drops it back to zero
        @(posedge clk) v = rdData_r;
    endtask
    // polls the control register until the single pass has cleared enable
    task automatic wait_pass;
        for (int i = 0; i < 60; i++) begin
            rd(OFF_CTRL, d);
            if (d[CTRL_EN] === 1'b0) break;
        end
        `CHK(d[CTRL_EN], 1'b0)
    endtask
    task automatic t_reset;
        rd(OFF_CTRL, d);          `CHK(d, 16'h0000)
        rd(OFF_CHDIS, d);         `CHK(d, 16'h0000)
        rd(OFF_RESULT0 + 8'h5, d); `CHK(d, RST_RESULT)
        rd(8'h20, d);             `CHK(d, 16'h0000)
        `CHK(biasRegulatorOn_r, 1'b1)
        `CHK(convPowerOn_r, 1'b0)
        `CHK(currentSenseAmpOn_r, 1'b1)
        batteryOnly <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(currentSenseAmpOn_r, 1'b0)
        wr(OFF_CTRL, 16'h0040);
        repeat (2) @(posedge clk);
        `CHK(currentSenseAmpOn_r, 1'b1)
        batteryOnly <= 1'b0;
        $display("test reset done");
    endtask
    task automatic t_oneshot;
        wr(OFF_CHDIS, 16'h00f6);
        repeat (2) @(posedge clk);
        `CHK(biasRegulatorOn_r, 1'b0)
        wr(OFF_CTRL, 16'h0003);
        wait_pass();
        `CHK(starts, 2)
        `CHK(alerts, 1)
        `CHK(convPowerOn_r, 1'b0)
        rd(OFF_RESULT0, d);        `CHK(d, 16'ha000)
        rd(OFF_RESULT0 + 8'h3, d); `CHK(d, 16'ha003)
        rd(OFF_RESULT0 + 8'h6, d); `CHK(d, 16'h0000)
        rd(OFF_STATUS, d);         `CHK(d[STS_DONE], 1'b1)
        rd(OFF_FLAG, d);           `CHK(d[FLG_DONE], 1'b1)
        rd(OFF_FLAG, d);           `CHK(d[FLG_DONE], 1'b0)
        $display("test oneshot done");
    endtask
    task automatic t_masked_zero;
        trickleCharge <= 1'b1;
        wr(OFF_CTRL, 16'h0083);
        wait_pass();
        `CHK(alerts, 1)
        rd(OFF_RESULT0 + 8'h3, d); `CHK(d, 16'h0000)
        rd(OFF_RESULT0, d);        `CHK(d, 16'ha000)
        trickleCharge <= 1'b0;
        $display("test mask done");
    endtask
    task automatic t_supply;
        vbusOk <= 1'b0;
        s0 = starts;
        wr(OFF_CTRL, 16'h0003);
        repeat (20) @(posedge clk);
        `CHK(starts, s0)
        acSenseOk <= 1'b1;
        wait_pass();
        `CHK(starts, s0 + 2)
        $display("test supply done");
    endtask
    task automatic t_continuous;
        s0 = starts;
        wr(OFF_CTRL, 16'h0001);
        repeat (40) @(posedge clk);
        rd(OFF_STATUS, d); `CHK(d[STS_DONE], 1'b0)
        rd(OFF_FLAG, d);   `CHK(d[FLG_DONE], 1'b0)
        `CHK(starts > s0 + 4, 1'b1)
        wr(OFF_CTRL, 16'h0000);
        repeat (2) @(posedge clk);
        s0 = starts;
        `CHK(convPowerOn_r, 1'b0)
        repeat (20) @(posedge clk);
        `CHK(starts, s0)
        $display("test continuous done");
    endtask
    task automatic t_speed;
        s0 = starts;
        wr(OFF_CTRL, 16'h0003);
        repeat (2) @(posedge clk);
        // speed change lands while channel 0 is converting
        wr(OFF_CTRL, 16'h0013);
        wait_pass();
        `CHK(starts, s0 + 3)
        `CHK(convSpeed_r, 2'h1)
        $display("test speed done");
    endtask
    task automatic t_hold;
        s0 = starts;
        wr(OFF_CTRL, 16'h0013);
        repeat (3) @(posedge clk);
        adapterInsert <= 1'b1;
        @(posedge clk) adapterInsert <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK(starts, s0 + 1)
        rd(OFF_STATUS, d); `CHK(d[STS_HOLD], 1'b1)
        detectionDone <= 1'b1;
        @(posedge clk) detectionDone <= 1'b0;
        wait_pass();
        `CHK(starts, s0 + 3)
        $display("test hold done");
    endtask
    task automatic t_avg;
        wr(OFF_CHDIS, 16'h00f7);
        trickleCharge <= 1'b1;
        wr(OFF_CTRL, 16'h0007);
        wait_pass();
        rd(OFF_RESULT0 + 8'h3, d); `CHK(d, 16'h5001)
        trickleCharge <= 1'b0;
        wr(OFF_CTRL, 16'h000f);
        wait_pass();
        rd(OFF_RESULT0 + 8'h3, d); `CHK(d, 16'ha003)
        $display("test average done");
    endtask
    task automatic t_alloff;
        s0 = starts;
        wr(OFF_CHDIS, 16'h00ff);
        wr(OFF_CTRL, 16'h0001);
        repeat (20) @(posedge clk);
        `CHK(starts, s0)
        rd(OFF_STATUS, d); `CHK(d[STS_BUSY], 1'b1)
        wr(OFF_CHDIS, 16'h00fe);
        repeat (10) @(posedge clk);
        `CHK(starts > s0, 1'b1)
        wr(OFF_CHDIS, 16'h00ff);
        repeat (10) @(posedge clk);
        s0 = starts;
        repeat (20) @(posedge clk);
        `CHK(starts, s0)
        rd(OFF_RESULT0, d); `CHK(d, 16'ha000)
        wr(OFF_CTRL, 16'h0000);
        $display("test all off done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_oneshot();
        t_masked_zero();
        t_supply();
        t_continuous();
        t_speed();
        t_hold();
        t_avg();
        t_alloff();
        final_report();
    end
endmodule
